// file: sr_relay_logic.sv
// Functional notes
// - init phase, mode latch, power, ready
// - input one closed lights and drives output one
// - input one open clears output one
// - output two only on three-way AND
// - any AND term false holds output two low
// - gate aux output follows input two alone
// - open feedback before switch-on flags error
// - after that, wait feedback closed and reopening
// - feedback must close 150 ms after switch-off
// - timeout error latches until power cycle
// - automatic start activates on closed input
// - monitored start activates on button release
// - dual channel detects earth faults as errors
// - each feedback terminal serves its own channel
// - periodic off-test of each output
`timescale 1ns/100ps
module sr_relay_logic #(
    parameter logic [sr_pkg::TW-1:0] FB_TIMEOUT_CYC_P = sr_pkg::FB_TIMEOUT_CYC,
    parameter logic [sr_pkg::TW-1:0] INIT_CYC_P = sr_pkg::INIT_CYC,
    parameter logic [sr_pkg::TW-1:0] DEB_CYC_P = sr_pkg::DEB_CYC,
    parameter logic [sr_pkg::TW-1:0] DISC_CYC_P = sr_pkg::DISC_CYC,
    parameter logic [sr_pkg::TW-1:0] TEST_PERIOD_CYC_P = sr_pkg::TEST_PERIOD_CYC,
    parameter logic [sr_pkg::TW-1:0] TEST_PULSE_CYC_P = sr_pkg::TEST_PULSE_CYC,
    parameter logic [sr_pkg::TW-1:0] BLINK_CYC_P = sr_pkg::BLINK_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic in1_contact_a,
    input wire logic in1_contact_b,
    input wire logic in2_nc_contact,
    input wire logic in2_no_contact,
    input wire logic cascade_and_input,
    input wire logic feedback_loop_one,
    input wire logic feedback_loop_two,
    input wire logic start_button,
    input wire logic safety_sense_one,
    input wire logic safety_sense_two,
    output logic safety_out_one,
    output logic safety_out_two,
    output logic combined_aux_output,
    output logic gate_status_aux_output,
    output logic channel_one_indicator,
    output logic channel_two_indicator,
    output logic power_indicator,
    output logic cascade_source_terminal,
    output logic input_supply_terminal
);
    import sr_pkg::*;

    // register address match, used by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic [NUM_IN-1:0] raw; // contact pins as gathered
    logic [NUM_IN-1:0] pin; // debounced contacts
    logic [1:0] sns1_q, sns2_q; // off-test readback sync
    logic [TW-1:0] init_cnt_q;
    logic init_done_q, ready_q;
    logic [1:0] mon_q; // monitored start per channel
    logic dual_q;
    logic [TW-1:0] disc_cnt_q;
    logic earth_q, fatal_q;
    logic [TW-1:0] tp_cnt_q;
    logic tp_on, tp_last;
    logic c1, gate;
    logic [1:0] cond, fb, lock, to_hit, ot_fail, lock_ev;
    logic [1:0] lock_d; // channel enters or stays in a lock next
    logic lock_any;
    sr_ch_t st_q [2];
    logic [1:0] out_q, aux_q, led_q;
    logic gate_q, power_q, src_q, sup_q;
    logic flash_alt, flash_code;
    logic [STW-1:0] status_q, mask_q, ev;
    logic [2:0] ctrl_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;
    logic acc, wr, mapped;

    assign raw[IX_IN1A] = in1_contact_a;
    assign raw[IX_IN1B] = in1_contact_b;
    assign raw[IX_IN2NC] = in2_nc_contact;
    assign raw[IX_IN2NO] = in2_no_contact;
    assign raw[IX_CASC] = cascade_and_input;
    assign raw[IX_FB1] = feedback_loop_one;
    assign raw[IX_FB2] = feedback_loop_two;
    assign raw[IX_START] = start_button;

    sr_debounce #(.DEB_CYC_P(DEB_CYC_P)) u_deb (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .raw(raw),
        .clean(pin)
    );

    sr_flash #(.BLINK_CYC_P(BLINK_CYC_P)) u_flash (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .alt_q(flash_alt),
        .code_q(flash_code)
    );

    // readback is not filtered: the filter would swallow the off-pulse
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sns1_q <= 2'h0;
            sns2_q <= 2'h0;
        end else if (ce) begin
            sns1_q <= {sns1_q[0], safety_sense_one};
            sns2_q <= {sns2_q[0], safety_sense_two};
        end
    end

    // single mode ignores the second contact
    assign c1 = pin[IX_IN1A] & (pin[IX_IN1B] | ~dual_q);
    // gate closed: n/c closed and n/o open
    assign gate = pin[IX_IN2NC] & ~pin[IX_IN2NO];
    assign cond = {c1 & gate & pin[IX_CASC], c1};
    // each feedback terminal serves its own channel
    assign fb = {pin[IX_FB2], pin[IX_FB1]};
    assign lock_any = |lock;

    // init phase, then latch mode and wait for feedback
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            init_cnt_q <= '0;
            init_done_q <= 1'b0;
            ready_q <= 1'b0;
            mon_q <= 2'h0;
            dual_q <= 1'b0;
        end else if (ce) begin
            if (!init_done_q) begin
                init_cnt_q <= init_cnt_q + 23'h1;
                if (init_cnt_q == INIT_CYC_P - 23'h1) begin
                    init_done_q <= 1'b1;
                    mon_q <= {ctrl_q[CT_MON2], ctrl_q[CT_MON1]};
                    dual_q <= ctrl_q[CT_DUAL];
                end
            end else if (&fb) begin
                ready_q <= 1'b1;
            end
        end
    end

    // contact discrepancy or stuck start button is an earth fault
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            disc_cnt_q <= '0;
            earth_q <= 1'b0;
        end else if (ce) begin
            if (!dual_q || pin[IX_IN1A] == pin[IX_IN1B]) begin
                disc_cnt_q <= '0;
            end else if (disc_cnt_q != DISC_CYC_P - 23'h1) begin
                disc_cnt_q <= disc_cnt_q + 23'h1;
            end
            // setting wins over the clear on both contacts open
            if ((dual_q && disc_cnt_q == DISC_CYC_P - 23'h1) ||
                (init_cnt_q == INIT_CYC_P - 23'h1 && !init_done_q &&
                 ctrl_q[CT_DUAL] && pin[IX_START])) begin
                earth_q <= 1'b1;
            end else if (!pin[IX_IN1A] && !pin[IX_IN1B] && !pin[IX_START]) begin
                earth_q <= 1'b0;
            end
        end
    end

    // off-test timer shared by both outputs
    assign tp_on = (tp_cnt_q >= TEST_PERIOD_CYC_P - TEST_PULSE_CYC_P);
    assign tp_last = (tp_cnt_q == TEST_PERIOD_CYC_P - 23'h1);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tp_cnt_q <= '0;
        end else if (ce) begin
            tp_cnt_q <= tp_last ? '0 : tp_cnt_q + 23'h1;
        end
    end

    // timeout or failed off-test: only reset clears it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fatal_q <= 1'b0;
        end else if (ce && (|to_hit || |ot_fail)) begin
            fatal_q <= 1'b1;
        end
    end

    genvar i;
    // per-channel start, feedback and output logic
    for (i = 0; i < 2; i++) begin : g_ch
        sr_ch_t st_d;
        logic [TW-1:0] cnt_q; // switch-off feedback timer
        logic pressed_q; // start button seen pressed
        logic go, en;
        // automatic start, or release of a press
        assign go = cond[i] & (~mon_q[i] | (pressed_q & ~pin[IX_START]));
        assign en = ready_q & ~fatal_q & ~earth_q & ~lock_any;
        assign lock[i] = (st_q[i] == CH_LOCK);
        // wait reaches its limit with feedback still open
        assign to_hit[i] = (st_q[i] == CH_FBW) & ~fb[i] &
                           (cnt_q == FB_TIMEOUT_CYC_P - 23'h1);
        // output still reads high at the end of its off-pulse
        assign ot_fail[i] = tp_last & (st_q[i] == CH_ON) &
                            (i == 0 ? sns1_q[1] : sns2_q[1]);
        assign lock_d[i] = (st_d == CH_LOCK);
        assign lock_ev[i] = lock_d[i] & ~lock[i];

        // next channel state
        always_comb begin
            st_d = st_q[i];
            case (st_q[i])
                CH_IDLE: begin
                    if (go && en) begin
                        st_d = fb[i] ? CH_ON : CH_LOCK;
                    end
                end
                CH_ON: begin
                    // a lock on either channel too
                    if (!cond[i] || fatal_q || earth_q || lock_any) begin
                        st_d = CH_FBW;
                    end
                end
                CH_FBW: begin
                    if (fb[i]) begin
                        st_d = CH_IDLE;
                    end
                end
                CH_LOCK: begin
                    // needs feedback closed and inputs reopened
                    if (!cond[i] && fb[i]) begin
                        st_d = CH_IDLE;
                    end
                end
                default: begin
                    st_d = CH_IDLE;
                end
            endcase
        end

        // state, timers and registered outputs
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                st_q[i] <= CH_IDLE;
                cnt_q <= '0;
                pressed_q <= 1'b0;
                out_q[i] <= 1'b0;
                aux_q[i] <= 1'b0;
                led_q[i] <= 1'b0;
            end else if (ce) begin
                st_q[i] <= st_d;
                // count only while waiting with feedback open
                if (st_q[i] == CH_FBW && !fb[i] && !to_hit[i]) begin
                    cnt_q <= cnt_q + 23'h1;
                end else if (st_q[i] != CH_FBW) begin
                    cnt_q <= '0;
                end
                // a press counts only with the input closed
                if (!mon_q[i] || !cond[i] || st_q[i] != CH_IDLE) begin
                    pressed_q <= 1'b0;
                end else if (pin[IX_START]) begin
                    pressed_q <= 1'b1;
                end
                out_q[i] <= (st_d == CH_ON) & ~tp_on;
                aux_q[i] <= (st_d == CH_ON);
                // code on timeout, alternate on a lock
                if (fatal_q) begin
                    led_q[i] <= flash_code;
                // next state, so the flash ends as the lock is left
                end else if (|lock_d) begin
                    led_q[i] <= flash_alt ^ (i == 1);
                end else begin
                    led_q[i] <= (st_d == CH_ON);
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gate_q <= 1'b0;
            power_q <= 1'b0;
            src_q <= 1'b0;
            sup_q <= 1'b0;
        end else if (ce) begin
            gate_q <= gate;
            power_q <= init_done_q;
            src_q <= init_done_q;
            sup_q <= init_done_q;
        end
    end

    // apb: answer one cycle into the access phase
    assign acc = psel & penable;
    assign wr = acc & pready_q & pwrite;
    assign mapped = hit(paddr, ADDR_STATUS) | hit(paddr, ADDR_MASK) |
                    hit(paddr, ADDR_STATE) | hit(paddr, ADDR_CTRL);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            mask_q <= MASK_RST;
            ctrl_q <= CTRL_RST;
        end else if (ce) begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            if (acc && !pready_q && !pwrite) begin
                prdata_q <= 32'h0000_0000;
                if (hit(paddr, ADDR_STATUS)) prdata_q[STW-1:0] <= status_q;
                if (hit(paddr, ADDR_MASK)) prdata_q[STW-1:0] <= mask_q;
                if (hit(paddr, ADDR_CTRL)) prdata_q[2:0] <= ctrl_q;
                if (hit(paddr, ADDR_STATE)) begin
                    prdata_q[11:0] <= {dual_q, mon_q, ready_q, init_done_q,
                                       fatal_q, earth_q, st_q[1], st_q[0],
                                       out_q[1]};
                    prdata_q[12] <= out_q[0];
                end
            end
            if (wr && hit(paddr, ADDR_MASK)) mask_q <= pwdata[STW-1:0];
            if (wr && hit(paddr, ADDR_CTRL)) ctrl_q <= pwdata[2:0];
        end
    end

    // sticky events, write one to clear, a new event wins
    assign ev = {|ot_fail, earth_q, |to_hit, lock_ev};
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_q <= STATUS_RST;
            irq_q <= 1'b0;
        end else if (ce) begin
            status_q <= (status_q & ~((wr && hit(paddr, ADDR_STATUS)) ?
                         pwdata[STW-1:0] : 5'h00)) | ev;
            irq_q <= |(status_q & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign safety_out_one = out_q[0];
    assign safety_out_two = out_q[1];
    assign combined_aux_output = aux_q[1];
    assign gate_status_aux_output = gate_q;
    assign channel_one_indicator = led_q[0];
    assign channel_two_indicator = led_q[1];
    assign power_indicator = power_q;
    assign cascade_source_terminal = src_q;
    assign input_supply_terminal = sup_q;

    // checks on the design's own outputs and states
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence s_press_release;
        g_ch[0].pressed_q && !pin[IX_START];
    endsequence
    sequence s_idle_ready(int n);
        ce && st_q[n] == CH_IDLE && cond[n] && ready_q && !fatal_q &&
        !earth_q && !lock_any;
    endsequence

    a_ready_after_init: assert property (
        !init_done_q |-> !ready_q && !power_q)
        else $error("ready before initialisation ended");
    a_out1_drops: assert property (
        ce && !cond[0] |=> !safety_out_one && !channel_one_indicator ||
        lock_any || fatal_q)
        else $error("output one high with input one open");
    a_out2_and_low: assert property (
        ce && !cond[1] |=> !safety_out_two && !combined_aux_output)
        else $error("output two high with AND false");
    a_gate_follows: assert property (
        ce |=> gate_status_aux_output == $past(gate))
        else $error("gate status aux wrong");
    a_pre_check_lock: assert property (
        s_idle_ready(0) ##0 (!mon_q[0] && !fb[0]) |=> st_q[0] == CH_LOCK)
        else $error("open feedback not caught before switch-on");
    a_lock_outs_off: assert property (
        ce && lock_any |=> !safety_out_one && !safety_out_two)
        else $error("output on during feedback lock");
    a_fb_timeout: assert property (
        ce && to_hit[0] |=> fatal_q ##0 st_q[0] == CH_FBW)
        else $error("feedback timeout not raised");
    a_fatal_sticky: assert property (
        fatal_q |=> fatal_q && !safety_out_one && !safety_out_two)
        else $error("timeout error cleared or output on");
    a_auto_start: assert property (
        s_idle_ready(0) ##0 (!mon_q[0] && fb[0]) |=> st_q[0] == CH_ON)
        else $error("automatic start did not activate");
    a_mon_release: assert property (
        mon_q[0] && st_q[0] == CH_IDLE ##1 st_q[0] == CH_ON
        |-> $past(g_ch[0].pressed_q) && !$past(pin[IX_START]))
        else $error("monitored start activated without release");
    a_offtest_fail: assert property (
        ce && ot_fail[0] |=> fatal_q ##1 !safety_out_one)
        else $error("failed off-test not detected");
endmodule : sr_relay_logic

// file: sr_pkg.sv
package sr_pkg;
    // clock rate in kHz: 40 MHz, 25 ns period
    localparam int CLK_KHZ = 40000;
    // timer width shared by every long counter
    localparam int TW = 23;
    // feedback must close within this time after switch-off (longest)
    localparam int FB_TIMEOUT_MS = 150;
    localparam logic [TW-1:0] FB_TIMEOUT_CYC = TW'(FB_TIMEOUT_MS * CLK_KHZ);
    // power-on initialisation phase (least)
    localparam int INIT_MS = 10;
    localparam logic [TW-1:0] INIT_CYC = TW'(INIT_MS * CLK_KHZ);
    // contact debounce filter (least)
    localparam int DEB_US = 1000;
    localparam logic [TW-1:0] DEB_CYC = TW'((DEB_US * CLK_KHZ + 999) / 1000);
    // allowed discrepancy of the redundant contacts (longest)
    localparam int DISC_MS = 50;
    localparam logic [TW-1:0] DISC_CYC = TW'(DISC_MS * CLK_KHZ);
    // off-test period and off-pulse length
    localparam int TEST_PERIOD_MS = 100;
    localparam logic [TW-1:0] TEST_PERIOD_CYC = TW'(TEST_PERIOD_MS * CLK_KHZ);
    localparam int TEST_PULSE_US = 200;
    localparam logic [TW-1:0] TEST_PULSE_CYC =
        TW'((TEST_PULSE_US * CLK_KHZ + 999) / 1000);
    // indicator blink half period
    localparam int BLINK_MS = 200;
    localparam logic [TW-1:0] BLINK_CYC = TW'(BLINK_MS * CLK_KHZ);
    // flash code 1,8: flashes per group, two blink ticks each
    localparam logic [4:0] FLASH_HI = 5'h01;
    localparam logic [4:0] FLASH_LO = 5'h08;
    localparam logic [4:0] FL_G2S = 5'(2 * FLASH_HI + 2);
    localparam logic [4:0] FL_G2E = 5'(FL_G2S + 2 * FLASH_LO);
    localparam logic [4:0] FL_END = 5'(FL_G2E + 3);
    // debounced contact inputs, bit positions
    localparam int NUM_IN = 8;
    localparam int IX_IN1A = 0;
    localparam int IX_IN1B = 1;
    localparam int IX_IN2NC = 2;
    localparam int IX_IN2NO = 3;
    localparam int IX_CASC = 4;
    localparam int IX_FB1 = 5;
    localparam int IX_FB2 = 6;
    localparam int IX_START = 7;
    // apb register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    // status and mask bits
    localparam int STW = 5;
    localparam int ST_LOCK1 = 0;
    localparam int ST_LOCK2 = 1;
    localparam int ST_FBTO = 2;
    localparam int ST_EARTH = 3;
    localparam int ST_OTEST = 4;
    localparam logic [STW-1:0] STATUS_RST = 5'h00;
    localparam logic [STW-1:0] MASK_RST = 5'h00;
    // control bits: monitored start per channel, dual-channel mode
    localparam int CT_MON1 = 0;
    localparam int CT_MON2 = 1;
    localparam int CT_DUAL = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // channel state, gray along idle-on-wait
    typedef enum logic [1:0] {
        CH_IDLE = 2'h0,
        CH_ON = 2'h1,
        CH_FBW = 2'h3,
        CH_LOCK = 2'h2
    } sr_ch_t;
endpackage : sr_pkg

// file: sr_debounce.sv
`timescale 1ns/100ps
module sr_debounce #(
    parameter logic [sr_pkg::TW-1:0] DEB_CYC_P = sr_pkg::DEB_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [sr_pkg::NUM_IN-1:0] raw,
    output logic [sr_pkg::NUM_IN-1:0] clean
);
    import sr_pkg::*;

    genvar g;
    // one synchroniser and filter per contact
    for (g = 0; g < NUM_IN; g++) begin : g_bit
        logic s1_q; // first stage, read only by s2_q
        logic s2_q;
        logic cl_q; // accepted level, open after reset
        logic [TW-1:0] cnt_q;
        assign clean[g] = cl_q;
        // level must hold a whole filter time before it is taken
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                cl_q <= 1'b0;
                cnt_q <= '0;
            end else if (ce) begin
                s1_q <= raw[g];
                s2_q <= s1_q;
                if (s2_q == cl_q) begin
                    cnt_q <= '0;
                end else if (cnt_q == DEB_CYC_P - 23'h1) begin
                    cl_q <= s2_q;
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_q + 23'h1;
                end
            end
        end
    end
endmodule : sr_debounce

// file: sr_flash.sv
`timescale 1ns/100ps
module sr_flash #(
    parameter logic [sr_pkg::TW-1:0] BLINK_CYC_P = sr_pkg::BLINK_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    output logic alt_q,
    output logic code_q
);
    import sr_pkg::*;

    logic [TW-1:0] pre_q; // blink prescaler
    logic [4:0] step_q; // position in the code sequence
    logic tick;

    assign tick = (pre_q == BLINK_CYC_P - 23'h1);

    // prescaler, alternating phase and code step
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pre_q <= '0;
            alt_q <= 1'b0;
            step_q <= 5'h00;
            code_q <= 1'b0;
        end else if (ce) begin
            pre_q <= tick ? '0 : pre_q + 23'h1;
            if (tick) begin
                alt_q <= ~alt_q;
                step_q <= (step_q == FL_END) ? 5'h00 : step_q + 5'h01;
            end
            // even steps inside a group light, code repeats forever
            code_q <= ~step_q[0] &
                      ((step_q < 5'(2 * FLASH_HI)) ||
                       (step_q >= FL_G2S && step_q < FL_G2E));
        end
    end
endmodule : sr_flash

// file: sr_field.sv
`timescale 1ns/100ps
// contactor model: its feedback contact opens while the coil is driven
module sr_field (
    input wire logic ref_clk,
    input wire logic out_one,
    input wire logic out_two,
    input wire logic stick_one,
    input wire logic stick_two,
    output logic fb_one,
    output logic fb_two
);
    // one loop per output
    // stick models a welded contact, held open on command only
    always_ff @(posedge ref_clk) begin
        fb_one <= !out_one && !stick_one;
        fb_two <= !out_two && !stick_two;
    end
endmodule : sr_field

// file: safety_relay_and_logic_test.sv
`timescale 1ns/100ps
module safety_relay_and_logic_test;
    import sr_pkg::*;
    // apb side, driven after rising edges only
    logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, se;
    // contacts, all open at start
    logic a = 0, b = 0, nc = 0, no = 0, cas = 0, btn = 0, st1 = 0;
    // clock enable, and a readback stuck high for the off-test
    logic ce = 1, so = 0;
    logic fb1, fb2, o1, o2, cmb, gate, led1, led2, pwr, src, sup;
    logic [1:0] on; // outputs seen outside the off-pulse
    int fails = 0, checks_done = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    // shortened timings; the off-pulse comes every t_per cycles
    localparam logic [TW-1:0] T_FB = 23'h28, T_INIT = 23'h8;
    localparam logic [TW-1:0] T_DEB = 23'h2, T_DISC = 23'h14;
    localparam logic [TW-1:0] T_PER = 23'hC8, T_PUL = 23'hA;
    localparam logic [TW-1:0] T_BLINK = 23'h4;
    sr_relay_logic #(.FB_TIMEOUT_CYC_P(T_FB), .INIT_CYC_P(T_INIT),
        .DEB_CYC_P(T_DEB), .DISC_CYC_P(T_DISC),
        .TEST_PERIOD_CYC_P(T_PER), .TEST_PULSE_CYC_P(T_PUL),
        .BLINK_CYC_P(T_BLINK)) dut_u (.ref_clk(ref_clk), .srst(srst),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .in1_contact_a(a), .in1_contact_b(b),
        .in2_nc_contact(nc), .in2_no_contact(no), .cascade_and_input(cas),
        .feedback_loop_one(fb1), .feedback_loop_two(fb2),
        .start_button(btn), .safety_sense_one(o1 | so),
        .safety_sense_two(o2), .safety_out_one(o1), .safety_out_two(o2),
        .combined_aux_output(cmb), .gate_status_aux_output(gate),
        .channel_one_indicator(led1), .channel_two_indicator(led2),
        .power_indicator(pwr), .cascade_source_terminal(src),
        .input_supply_terminal(sup));
    sr_field field_u (.ref_clk(ref_clk), .out_one(o1), .out_two(o2),
        .stick_one(st1), .stick_two(1'b0), .fb_one(fb1), .fb_two(fb2));
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // outputs sampled twice, further apart than one off-pulse
    task automatic look;
        on = {o1, o2};
        tick(12);
        on = on | {o1, o2};
    endtask : look
    // one apb transfer; waits for pready with no assumed latency
    task automatic apb(input logic wr, input logic [7:0] ad,
        input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // reset, then mode written inside the init phase
    task automatic boot(input logic [31:0] ctl);
        srst <= 1;
        tick(4);
        srst <= 0;
        apb(1, ADDR_CTRL, ctl);
        tick(12);
    endtask : boot
    // hang guard, run needs well under two thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        boot(32'h0);
        chk({pwr, src, sup}, 3'h7);
        a <= 1; b <= 1; nc <= 1;
        tick(10);
        look;
        chk({on[1], led1, gate, on[0]}, 4'hE);
        cas <= 1;
        tick(10);
        look;
        chk({on[0], cmb, led2}, 3'h7);
        no <= 1;
        tick(10);
        chk({o2, cmb, gate}, 3'h0);
        a <= 0; b <= 0;
        tick(10);
        chk({o1, led1}, 2'h0);
        // welded contactor one, then try to switch on
        apb(1, ADDR_MASK, 32'h1);
        st1 <= 1;
        tick(10);
        a <= 1; b <= 1;
        tick(10);
        apb(0, ADDR_STATUS, 32'h0);
        chk({o1, rd[ST_LOCK1], irq, led1 ^ led2}, 4'h7);
        st1 <= 0;
        tick(10);
        chk(o1, 0);
        a <= 0; b <= 0;
        tick(10);
        a <= 1; b <= 1;
        tick(10);
        look;
        chk(on[1], 1);
        apb(1, ADDR_STATUS, 32'h1);
        tick(2);
        chk(irq, 0);
        // feedback stays open after switch-off
        st1 <= 1;
        a <= 0; b <= 0;
        tick(30);
        apb(0, ADDR_STATUS, 32'h0);
        chk(rd[ST_FBTO], 0);
        tick(30);
        apb(0, ADDR_STATUS, 32'h0);
        chk(rd[ST_FBTO], 1);
        st1 <= 0;
        a <= 1; b <= 1;
        tick(10);
        chk(o1, 0);
        apb(0, 8'h10, 32'h0);
        chk(se, 1);
        chk(rd, 0);
        // monitored start on channel one, dual channel
        a <= 0; b <= 0; nc <= 0; no <= 0; cas <= 0;
        boot(32'h5);
        a <= 1;
        tick(40);
        apb(0, ADDR_STATUS, 32'h0);
        chk({rd[ST_EARTH], o1}, 2'h2);
        a <= 0;
        tick(10);
        a <= 1; b <= 1;
        tick(10);
        btn <= 1;
        tick(10);
        chk(o1, 0);
        btn <= 0;
        tick(10);
        look;
        chk(on[1], 1);
        // a low clock enable freezes the gate status
        ce <= 0;
        nc <= 1;
        tick(10);
        chk(gate, 0);
        ce <= 1;
        tick(10);
        chk(gate, 1);
        // readback stuck high must fail the next off-test
        so <= 1;
        tick(210);
        apb(0, ADDR_STATUS, 32'h0);
        chk({rd[ST_OTEST], o1}, 2'h2);
        wrap_up();
    end
endmodule : safety_relay_and_logic_test
